// *** equation_engine.sv ***
`timescale 1ns/1ps
// Operation
// R01 - Insert or delete entry anywhere in list
// R02 - Stop evaluation at first end marker
// R03 - Rising one-shot fires on false to true
// R04 - Falling one-shot fires on true to false
// R05 - Dual one-shot fires on any change
// R06 - One-shot output true for one pass
// R07 - 32 one-shots, each keeps previous input
// R08 - Inverter complements the single preceding result
// R09 - OR/AND/NOR/NAND take 2 to 16 inputs
// R10 - Exclusive-OR takes exactly two inputs
// R11 - NOR all false, NAND any false, XOR one
// R12 - Latch is reset dominant, else holds
// R13 - Latch reset is preceding, set before that
// R14 - 32 timers started by preceding result
// R15 - Assignment copies result into flag 1-64
// R16 - Operands placed before their consuming operator
// R17 - Each operator yields one result
// R18 - Assignment ends the current equation
// R19 - Duplicate timer or assignment is syntax error
// R20 - Entries evaluated strictly in stored order
// R21 - Latches cleared at power up
// R22 - Any new setting recompiles and clears latches
// R23 - Intermediate results kept on a stack
module equation_engine (
  // Clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   resetn,
  // Pass timing
  input  wire logic                                   pass_tick,
  // List editing
  input  wire equation_pkg::edit_req_t                edit_req,
  // Operand sources
  input  wire logic [equation_pkg::OPERAND_COUNT-1:0] operand_in,
  // Results
  output logic [equation_pkg::FLAG_COUNT-1:0]         soft_output_flag,
  output logic [equation_pkg::SLOT_COUNT-1:0]         timer_out,
  // Status
  output logic                                        pass_done,
  output logic                                        busy,
  output logic                                        syntax_error,
  output logic [equation_pkg::LEN_W-1:0]              list_len
);

  // ************************************************************
  // State and working signals
  // ************************************************************
  equation_pkg::engine_state_t        st;
  equation_pkg::engine_state_t        next_st;
  equation_pkg::entry_t               rd_data;
  equation_pkg::entry_t               mem_wd;
  equation_pkg::entry_t               e;
  equation_pkg::stack_ctl_t           stk;
  logic [equation_pkg::LIST_AW-1:0]   mem_ra;
  logic [equation_pkg::LIST_AW-1:0]   mem_wa;
  logic                               mem_we;
  logic [equation_pkg::GATE_W-1:0]    top;
  logic [equation_pkg::GATE_W-1:0]    mask;
  logic [equation_pkg::POP_W-1:0]     n;
  logic [equation_pkg::SLOT_W-1:0]    sidx;
  logic [equation_pkg::FLAG_W-1:0]    fidx;
  logic                               res;
  logic                               bad;
  logic                               at_end;

  // Gate result over the inputs selected by mask
  function automatic logic gate_eval(equation_pkg::op_t op,
                                     logic [equation_pkg::GATE_W-1:0] m,
                                     logic [equation_pkg::GATE_W-1:0] t);
    logic any_true;
    logic all_true;
    any_true = |(t & m);
    all_true = &(t | ~m);
    unique case (op)
      equation_pkg::OP_OR:   return any_true;
      equation_pkg::OP_AND:  return all_true;
      equation_pkg::OP_NOR:  return ~any_true;
      equation_pkg::OP_NAND: return ~all_true;
      default:               return 1'b0;
    endcase
  endfunction

  // ************************************************************
  // Submodules
  // ************************************************************
  param_store u_store (
    .clk     (clk),
    .rd_addr (mem_ra),
    .rd_data (rd_data),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (mem_wd)
  );

  result_stack u_stack (
    .clk    (clk),
    .resetn (resetn),
    .ctl    (stk),
    .top    (top)
  );

  // ************************************************************
  // Decode of the current entry
  // ************************************************************
  assign e      = rd_data;
  assign n      = equation_pkg::pops_of(e);
  assign sidx   = e.arg[equation_pkg::SLOT_W-1:0];
  assign fidx   = equation_pkg::FLAG_W'(e.arg - equation_pkg::FLAG_FIRST);
  assign at_end = (st.pc >= st.len) || (e.op == equation_pkg::OP_END);

  // Input mask for the multi-input gates
  always_comb begin
    mask = '0;
    for (int i = 0; i < equation_pkg::GATE_W; i++) begin
      mask[i] = (i < int'(n)); // R09
    end
  end

  // Static check of one entry
  always_comb begin
    bad = !equation_pkg::arg_ok(e); // R09
    if ({1'b0, n} > st.chk_depth) begin
      bad = 1'b1; // R16
    end
    if ((st.chk_depth == equation_pkg::STACK_FULL) && (n == equation_pkg::POP_NONE)) begin
      bad = 1'b1;
    end
    if ((e.op == equation_pkg::OP_TIMER) && st.seen_tmr[sidx]) begin
      bad = 1'b1; // R19
    end
    if ((e.op == equation_pkg::OP_ASSIGN) && st.seen_flag[fidx]) begin
      bad = 1'b1; // R19
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st           = st;
    next_st.pass_done = 1'b0;
    mem_we            = 1'b0;
    mem_wa            = st.cur;
    mem_wd            = rd_data;
    mem_ra            = '0;
    stk               = '0;
    res               = 1'b0;
    if (pass_tick) begin
      next_st.pass_pending = 1'b1;
    end
    unique case (st.state)
      // Accept an edit, else start a pass
      equation_pkg::ST_IDLE: begin
        if (edit_req.valid) begin
          if (edit_req.cmd == equation_pkg::EDIT_INSERT) begin
            if (st.len < equation_pkg::LIST_FULL) begin
              next_st.entry = edit_req.entry;
              if (equation_pkg::LEN_W'(edit_req.pos) >= st.len) begin
                next_st.pos   = st.len[equation_pkg::LIST_AW-1:0]; // R01
                next_st.state = equation_pkg::ST_PLACE;
              end else begin
                next_st.pos   = edit_req.pos;
                next_st.cur   = st.len[equation_pkg::LIST_AW-1:0] - equation_pkg::ADDR_ONE;
                mem_ra        = next_st.cur;
                next_st.state = equation_pkg::ST_MOVE_UP; // R01
              end
            end
          end else if (equation_pkg::LEN_W'(edit_req.pos) < st.len) begin
            next_st.cur = edit_req.pos;
            if (equation_pkg::LEN_W'(edit_req.pos) + equation_pkg::LEN_ONE < st.len) begin
              mem_ra        = edit_req.pos + equation_pkg::ADDR_ONE;
              next_st.state = equation_pkg::ST_MOVE_DN; // R01
            end else begin
              next_st.state = equation_pkg::ST_SHRINK;
            end
          end
        end else if (st.pass_pending && !st.syntax_error) begin
          next_st.pass_pending = pass_tick;
          next_st.pc           = '0;
          mem_ra               = '0;
          stk.clear            = 1'b1;
          next_st.state        = equation_pkg::ST_EVAL;
        end
      end
      // Open a gap: move one entry up
      equation_pkg::ST_MOVE_UP: begin
        mem_we = 1'b1;
        mem_wa = st.cur + equation_pkg::ADDR_ONE; // R01
        mem_wd = rd_data;
        if (st.cur == st.pos) begin
          next_st.state = equation_pkg::ST_PLACE;
        end else begin
          next_st.cur = st.cur - equation_pkg::ADDR_ONE;
          mem_ra      = next_st.cur;
        end
      end
      // Write the new entry into the gap
      equation_pkg::ST_PLACE: begin
        mem_we        = 1'b1;
        mem_wa        = st.pos;
        mem_wd        = st.entry;
        next_st.len   = st.len + equation_pkg::LEN_ONE;
        next_st.state = equation_pkg::ST_COMPILE;
      end
      // Close a gap: move one entry down
      equation_pkg::ST_MOVE_DN: begin
        mem_we      = 1'b1;
        mem_wa      = st.cur; // R01
        mem_wd      = rd_data;
        next_st.cur = st.cur + equation_pkg::ADDR_ONE;
        if (equation_pkg::LEN_W'(st.cur) + equation_pkg::LEN_TWO < st.len) begin
          mem_ra = st.cur + equation_pkg::ADDR_TWO;
        end else begin
          next_st.state = equation_pkg::ST_SHRINK;
        end
      end
      // Drop the last entry
      equation_pkg::ST_SHRINK: begin
        next_st.len   = st.len - equation_pkg::LEN_ONE;
        next_st.state = equation_pkg::ST_COMPILE;
      end
      // Recompile: clear latches, one-shots, timers, flags, check state and stack (not pass_pending or len) and scan the list
      equation_pkg::ST_COMPILE: begin
        next_st.latch        = '0; // R22
        next_st.shot_prev    = '0;
        next_st.timer        = '0;
        next_st.flags        = '0;
        next_st.seen_tmr     = '0;
        next_st.seen_flag    = '0;
        next_st.chk_depth    = '0;
        next_st.syntax_error = 1'b0;
        next_st.pc           = '0;
        mem_ra               = '0;
        stk.clear            = 1'b1;
        next_st.state        = equation_pkg::ST_CHECK;
      end
      // One entry per cycle of the syntax scan
      equation_pkg::ST_CHECK: begin
        if (at_end) begin
          next_st.state = equation_pkg::ST_IDLE; // R02
        end else if (bad) begin
          next_st.syntax_error = 1'b1; // R19
          next_st.state        = equation_pkg::ST_IDLE;
        end else begin
          if (e.op == equation_pkg::OP_TIMER) begin
            next_st.seen_tmr[sidx] = 1'b1;
          end
          if (e.op == equation_pkg::OP_ASSIGN) begin
            next_st.seen_flag[fidx] = 1'b1;
            next_st.chk_depth       = '0;
          end else begin
            next_st.chk_depth = st.chk_depth - equation_pkg::STACK_CW'(n)
                              + equation_pkg::STACK_ONE;
          end
          next_st.pc = st.pc + equation_pkg::LEN_ONE;
          mem_ra     = equation_pkg::LIST_AW'(next_st.pc);
        end
      end
      // One entry per cycle of an evaluation pass
      equation_pkg::ST_EVAL: begin
        if (at_end) begin
          next_st.pass_done = 1'b1; // R02
          stk.clear         = 1'b1;
          next_st.state     = equation_pkg::ST_IDLE;
        end else begin
          unique case (e.op)
            equation_pkg::OP_INPUT: begin
              res = operand_in[e.arg[equation_pkg::OPERAND_W-1:0]];
            end
            equation_pkg::OP_FLAG: begin
              res = st.flags[fidx]; // R20
            end
            equation_pkg::OP_TIMER_OUT: begin
              res = st.timer[sidx]; // R14
            end
            equation_pkg::OP_NOT: begin
              res = ~top[0]; // R08
            end
            equation_pkg::OP_OR, equation_pkg::OP_AND, equation_pkg::OP_NOR,
            equation_pkg::OP_NAND: begin
              res = gate_eval(e.op, mask, top); // R11
            end
            equation_pkg::OP_XOR: begin
              res = top[0] ^ top[1]; // R10
            end
            equation_pkg::OP_LATCH: begin
              if (top[0]) begin
                res = 1'b0; // R12
              end else if (top[1]) begin
                res = 1'b1; // R13
              end else begin
                res = st.latch[sidx];
              end
              next_st.latch[sidx] = res;
            end
            equation_pkg::OP_RISE: begin
              res                     = top[0] & ~st.shot_prev[sidx]; // R03
              next_st.shot_prev[sidx] = top[0]; // R07
            end
            equation_pkg::OP_FALL: begin
              res                     = ~top[0] & st.shot_prev[sidx]; // R04
              next_st.shot_prev[sidx] = top[0]; // R07
            end
            equation_pkg::OP_BOTH: begin
              res                     = top[0] ^ st.shot_prev[sidx]; // R05
              next_st.shot_prev[sidx] = top[0];
            end
            equation_pkg::OP_TIMER: begin
              res                 = top[0];
              next_st.timer[sidx] = top[0]; // R14
            end
            equation_pkg::OP_ASSIGN: begin
              next_st.flags[fidx] = top[0]; // R15
            end
            equation_pkg::OP_END: begin
              res = 1'b0;
            end
          endcase
          if (e.op == equation_pkg::OP_ASSIGN) begin
            stk.clear = 1'b1; // R18
          end else begin
            stk.en     = 1'b1; // R17
            stk.pop    = n; // R23
            stk.bit_in = res;
          end
          next_st.pc = st.pc + equation_pkg::LEN_ONE; // R20
          mem_ra     = equation_pkg::LIST_AW'(next_st.pc);
        end
      end
    endcase
    next_st.busy = (next_st.state != equation_pkg::ST_IDLE);
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0; // R21
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign soft_output_flag = st.flags;
  assign timer_out        = st.timer;
  assign pass_done        = st.pass_done;
  assign busy             = st.busy;
  assign syntax_error     = st.syntax_error;
  assign list_len         = st.len;

endmodule

// *** equation_pkg.sv ***
package equation_pkg;

  // ************************************************************
  // Sizes of the list, the stack and the slot arrays
  // ************************************************************
  localparam int LIST_DEPTH    = 256;
  localparam int LIST_AW       = 8;
  localparam int LEN_W         = 9;
  localparam int STACK_DEPTH   = 32;
  localparam int STACK_CW      = 6;
  localparam int GATE_W        = 16;
  localparam int POP_W         = 5;
  localparam int SLOT_COUNT    = 32;
  localparam int SLOT_W        = 5;
  localparam int FLAG_COUNT    = 64;
  localparam int FLAG_W        = 6;
  localparam int OPERAND_COUNT = 64;
  localparam int OPERAND_W     = 6;
  localparam int ARG_W         = 8;

  // ************************************************************
  // Limits and increments
  // ************************************************************
  localparam logic [LEN_W-1:0]    LIST_FULL    = 9'h100;
  localparam logic [LEN_W-1:0]    LEN_ONE      = 9'h001;
  localparam logic [LEN_W-1:0]    LEN_TWO      = 9'h002;
  localparam logic [LIST_AW-1:0]  ADDR_ONE     = 8'h01;
  localparam logic [LIST_AW-1:0]  ADDR_TWO     = 8'h02;
  localparam logic [STACK_CW-1:0] STACK_FULL   = 6'h20;
  localparam logic [STACK_CW-1:0] STACK_ONE    = 6'h01;
  localparam logic [POP_W-1:0]    POP_NONE     = 5'h00;
  localparam logic [POP_W-1:0]    POP_ONE      = 5'h01;
  localparam logic [POP_W-1:0]    POP_TWO      = 5'h02;
  localparam logic [ARG_W-1:0]    GATE_MIN     = 8'h02;
  localparam logic [ARG_W-1:0]    GATE_MAX     = 8'h10;
  localparam logic [ARG_W-1:0]    FLAG_FIRST   = 8'h01;
  localparam logic [ARG_W-1:0]    FLAG_LAST    = 8'h40;
  localparam logic [ARG_W-1:0]    SLOT_LAST    = 8'h1f;
  localparam logic [ARG_W-1:0]    OPERAND_LAST = 8'h3f;

  // ************************************************************
  // Entry format and command types
  // ************************************************************
  typedef enum logic [3:0] {
    OP_END, OP_INPUT, OP_FLAG, OP_TIMER_OUT, OP_NOT, OP_OR, OP_AND, OP_NOR,
    OP_NAND, OP_XOR, OP_LATCH, OP_RISE, OP_FALL, OP_BOTH, OP_TIMER, OP_ASSIGN
  } op_t;

  typedef struct packed {
    op_t              op;
    logic [ARG_W-1:0] arg;
  } entry_t;

  typedef enum logic {EDIT_INSERT, EDIT_DELETE} edit_cmd_t;

  typedef struct packed {
    logic               valid;
    edit_cmd_t          cmd;
    logic [LIST_AW-1:0] pos;
    entry_t             entry;
  } edit_req_t;

  typedef struct packed {
    logic             clear;
    logic             en;
    logic [POP_W-1:0] pop;
    logic             bit_in;
  } stack_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_MOVE_UP, ST_PLACE, ST_MOVE_DN, ST_SHRINK, ST_COMPILE, ST_CHECK, ST_EVAL
  } eng_state_t;

  typedef struct packed {
    eng_state_t            state;
    logic [LEN_W-1:0]      len;
    logic [LEN_W-1:0]      pc;
    logic [LIST_AW-1:0]    cur;
    logic [LIST_AW-1:0]    pos;
    entry_t                entry;
    logic [FLAG_COUNT-1:0] flags;
    logic [SLOT_COUNT-1:0] latch;
    logic [SLOT_COUNT-1:0] shot_prev;
    logic [SLOT_COUNT-1:0] timer;
    logic [SLOT_COUNT-1:0] seen_tmr;
    logic [FLAG_COUNT-1:0] seen_flag;
    logic [STACK_CW-1:0]   chk_depth;
    logic                  syntax_error;
    logic                  pass_pending;
    logic                  pass_done;
    logic                  busy;
  } engine_state_t;

  // Number of results an entry takes from the stack
  function automatic logic [POP_W-1:0] pops_of(entry_t e);
    unique case (e.op)
      OP_OR, OP_AND, OP_NOR, OP_NAND: return e.arg[POP_W-1:0];
      OP_XOR, OP_LATCH:                return POP_TWO;
      OP_NOT, OP_RISE, OP_FALL, OP_BOTH, OP_TIMER, OP_ASSIGN: return POP_ONE;
      default:                         return POP_NONE;
    endcase
  endfunction

  // Range check of an entry's argument
  function automatic logic arg_ok(entry_t e);
    unique case (e.op)
      OP_INPUT:                       return e.arg <= OPERAND_LAST;
      OP_FLAG, OP_ASSIGN:             return (e.arg >= FLAG_FIRST) && (e.arg <= FLAG_LAST);
      OP_OR, OP_AND, OP_NOR, OP_NAND: return (e.arg >= GATE_MIN) && (e.arg <= GATE_MAX);
      OP_TIMER_OUT, OP_LATCH, OP_RISE, OP_FALL, OP_BOTH, OP_TIMER: return e.arg <= SLOT_LAST;
      default:                        return 1'b1;
    endcase
  endfunction

endpackage

// *** param_store.sv ***
`timescale 1ns/1ps
module param_store (
  // Clock
  input  wire logic                          clk,
  // Read port
  input  wire logic [equation_pkg::LIST_AW-1:0] rd_addr,
  output equation_pkg::entry_t               rd_data,
  // Write port
  input  wire logic                          wr_en,
  input  wire logic [equation_pkg::LIST_AW-1:0] wr_addr,
  input  wire equation_pkg::entry_t          wr_data
);

  // ************************************************************
  // Storage
  // ************************************************************
  equation_pkg::entry_t mem [equation_pkg::LIST_DEPTH];

  // Write, and registered read of the old contents
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// *** result_stack.sv ***
`timescale 1ns/1ps
module result_stack (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            resetn,
  // Control
  input  wire equation_pkg::stack_ctl_t        ctl,
  // Top entries, index 0 is the newest
  output logic [equation_pkg::GATE_W-1:0]      top
);

  // ************************************************************
  // Stack held as a shift vector
  // ************************************************************
  logic [equation_pkg::STACK_DEPTH-1:0] st;
  logic [equation_pkg::STACK_DEPTH-1:0] next_st;

  // Pop the input count, then push one result
  always_comb begin
    next_st = st;
    if (ctl.clear) begin
      next_st = '0;
    end else if (ctl.en) begin
      next_st = ((st >> ctl.pop) << 1) | equation_pkg::STACK_DEPTH'(ctl.bit_in); // R23
    end
  end

  // Register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign top = st[equation_pkg::GATE_W-1:0];

endmodule

// *** equation_engine_assertions.sv ***
`timescale 1ns/1ps
module equation_engine_assertions (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    resetn,
  // Requests
  input wire logic                    pass_tick,
  input wire equation_pkg::edit_req_t edit_req,
  input wire logic [63:0]             operand_in,
  // Results and status
  input wire logic [63:0]             soft_output_flag,
  input wire logic [31:0]             timer_out,
  input wire logic                    pass_done,
  input wire logic                    busy,
  input wire logic                    syntax_error,
  input wire logic [8:0]              list_len
);
  // ************************************************************
  // Clocking and sequences
  // ************************************************************
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Idle, then a lone tick on an empty list
  sequence quiet_tick;
    !busy && !pass_tick && !edit_req.valid && !syntax_error
    ##1 pass_tick && !busy && !edit_req.valid && list_len == 9'h000
    ##1 !edit_req.valid;
  endsequence

  // Edit that must be accepted
  sequence edit_taken;
    edit_req.valid && !busy && (edit_req.cmd == equation_pkg::EDIT_INSERT ?
      list_len != equation_pkg::LIST_FULL : {1'b0, edit_req.pos} < list_len);
  endsequence

  // ************************************************************
  // Properties
  // ************************************************************
  reset_clear_a: assert property (disable iff (1'b0)
    !resetn |=> soft_output_flag == 64'h0 && timer_out == 32'h0 && list_len == 9'h000
      && !busy && !pass_done)
    else $error("outputs not cleared by reset");
  empty_pass_a: assert property (quiet_tick |-> ##2 pass_done)
    else $error("empty pass took wrong time");
  edit_busy_a: assert property (edit_taken |=> busy [*2])
    else $error("edit did not raise busy");
  busy_bound_a: assert property ($rose(busy) |-> ##[1:800] !busy)
    else $error("busy never fell");
  done_after_a: assert property (pass_done |-> !busy && $past(busy))
    else $error("pass done without a busy pass");
  done_pulse_a: assert property (pass_done |=> !pass_done)
    else $error("pass done longer than one cycle");
  error_block_a: assert property (syntax_error |-> !pass_done)
    else $error("pass ran with syntax error");
  len_step_a: assert property ($past(resetn) && list_len != $past(list_len) |-> busy
    && (list_len == $past(list_len) + 9'h001 || list_len + 9'h001 == $past(list_len)))
    else $error("list length jumped");
  out_hold_a: assert property ($past(resetn)
    && $changed({soft_output_flag, timer_out}) |-> busy)
    else $error("results changed while idle");
endmodule

bind equation_engine equation_engine_assertions u_equation_engine_assertions (
  .clk(clk), .resetn(resetn), .pass_tick(pass_tick), .edit_req(edit_req),
  .operand_in(operand_in), .soft_output_flag(soft_output_flag), .timer_out(timer_out),
  .pass_done(pass_done), .busy(busy), .syntax_error(syntax_error), .list_len(list_len)
);

// *** equation_engine_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin \
  checks_done++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); \
  end \
end
module equation_engine_tb_top;
  // ************************************************************
  // Signals and model state
  // ************************************************************
  logic                    clk;
  logic                    resetn;
  logic                    pass_tick;
  equation_pkg::edit_req_t edit_req;
  logic [63:0]             operand_in;
  logic [63:0]             soft_output_flag;
  logic [31:0]             timer_out;
  logic                    pass_done;
  logic                    busy;
  logic                    syntax_error;
  logic [8:0]              list_len;
  int                      fails;
  int                      checks_done;
  logic                    lat;
  logic                    prv;
  logic [63:0]             expf;
  // Entry codes below are {op[3:0], arg[7:0]}

  equation_engine u_equation_engine (
    .clk(clk), .resetn(resetn), .pass_tick(pass_tick), .edit_req(edit_req),
    .operand_in(operand_in), .soft_output_flag(soft_output_flag), .timer_out(timer_out),
    .pass_done(pass_done), .busy(busy), .syntax_error(syntax_error), .list_len(list_len)
  );

  // Free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic cyc;
    @(posedge clk);
    #1;
  endtask

  task automatic give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bounded wait for pass end or for idle
  task automatic wait_for(input bit want_done);
    int n;
    n = 0;
    while (want_done ? pass_done !== 1'b1 : busy !== 1'b0) begin
      cyc();
      n++;
      if (n > 3000) begin
        fails++;
        give_verdict();
      end
    end
  endtask

  task automatic edit(input equation_pkg::edit_cmd_t c, input logic [7:0] p,
                      input logic [11:0] x);
    wait_for(0);
    edit_req = '{1'b1, c, p, x};
    cyc();
    edit_req.valid = 1'b0;
    wait_for(0);
  endtask

  task automatic add(input logic [11:0] x);
    edit(equation_pkg::EDIT_INSERT, list_len[7:0], x);
  endtask

  task automatic tick;
    pass_tick = 1'b1;
    cyc();
    pass_tick = 1'b0;
  endtask

  // Expected flags for one pass
  task automatic model(input logic [63:0] v);
    lat = !v[5] && (v[4] || lat);
    expf = 64'h0;
    expf[0] = v[0] ^ v[1];
    expf[1] = ~|v[2:0];
    expf[2] = ~&v[1:0];
    expf[3] = &v[15:0];
    expf[4] = lat;
    expf[5] = v[6] && !prv;
    expf[6] = !v[6] && prv;
    expf[7] = v[6] ^ prv;
    expf[8] = v[7];
    expf[9] = v[7];
    expf[63] = !(expf[0] || expf[1]);
    prv = v[6];
  endtask

  task automatic pass(input logic [63:0] v);
    operand_in = v;
    model(v);
    tick();
    wait_for(1);
    `CHK(soft_output_flag, expf)
    `CHK(timer_out, {31'h0, expf[8]})
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    `CHK(list_len, 9'h000)
    cyc();
    tick();
    wait_for(1);
    `CHK(soft_output_flag, 64'h0)
    $display("test reset done");
  endtask

  task automatic t_build;
    logic [11:0] prog [54] = '{
      12'h100,12'h101,12'h900,12'hf01,12'h100,12'h101,12'h102,12'h703,12'hf02,
      12'h100,12'h101,12'h802,12'hf03,12'h100,12'h101,12'h102,12'h103,12'h104,
      12'h105,12'h106,12'h107,12'h108,12'h109,12'h10a,12'h10b,12'h10c,12'h10d,
      12'h10e,12'h10f,12'h610,12'hf04,12'h104,12'h105,12'ha00,12'hf05,12'h106,
      12'hb01,12'hf06,12'h106,12'hc02,12'hf07,12'h106,12'hd03,12'hf08,12'h107,
      12'he00,12'hf09,12'h300,12'hf0a,12'h201,12'h202,12'h502,12'h400,12'hf40};
    foreach (prog[i]) add(prog[i]);
    `CHK(list_len, 9'h036)
    `CHK(syntax_error, 1'b0)
    $display("test build done");
  endtask

  task automatic t_gates;
    logic [63:0] pat [7] = '{64'h0, 64'h1, 64'h2, 64'h3, 64'h7, 64'hffff, 64'h80};
    foreach (pat[i]) pass(pat[i]);
    $display("test gates done");
  endtask

  task automatic t_latch_shot;
    pass(64'h10);
    pass(64'h0);
    pass(64'h30);
    pass(64'h40);
    pass(64'h40);
    pass(64'h0);
    pass(64'h40);
    $display("test latch and shots done");
  endtask

  task automatic t_end;
    edit(equation_pkg::EDIT_INSERT, 8'h00, 12'h000);
    `CHK(list_len, 9'h037)
    operand_in = 64'hffff;
    tick();
    wait_for(1);
    `CHK(soft_output_flag, 64'h0)
    edit(equation_pkg::EDIT_DELETE, 8'h00, 12'h000);
    `CHK(list_len, 9'h036)
    {lat, prv} = 2'h0;
    pass(64'h3);
    $display("test end marker done");
  endtask

  task automatic t_recompile;
    pass(64'h90);
    add(12'h000);
    `CHK({soft_output_flag, timer_out}, 96'h0)
    edit(equation_pkg::EDIT_DELETE, list_len[7:0] - 8'h01, 12'h000);
    {lat, prv} = 2'h0;
    pass(64'h0);
    $display("test recompile done");
  endtask

  task automatic t_syntax;
    for (int i = 0; i < 2; i++) begin
      add(12'h100);
      add(i ? 12'he00 : 12'hf01);
      `CHK(syntax_error, 1'b1)
      tick();
      repeat (40) begin
        cyc();
        `CHK(pass_done, 1'b0)
      end
      edit(equation_pkg::EDIT_DELETE, list_len[7:0] - 8'h01, 12'h000);
      {lat, prv} = 2'h0;
      model(operand_in);
      wait_for(1);
      `CHK(soft_output_flag, expf)
      edit(equation_pkg::EDIT_DELETE, list_len[7:0] - 8'h01, 12'h000);
    end
    $display("test syntax done");
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    pass_tick = 1'b0;
    edit_req = '0;
    operand_in = 64'h0;
    fails = 0;
    checks_done = 0;
    {lat, prv, expf} = '0;
    repeat (16) cyc();
    resetn = 1'b1;
    cyc();
    t_reset();
    t_build();
    t_gates();
    t_latch_shot();
    t_end();
    t_recompile();
    t_syntax();
    give_verdict();
  end
endmodule
